// File: src/rseq_consts.svh
// Register offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RSEQ_CONSTS_SVH
`define RSEQ_CONSTS_SVH
`define OFS_STATUS 5'h00
`define OFS_IRQ_EN 5'h04
`define OFS_CTRL 5'h08
`define OFS_OPTION 5'h0c
`define OFS_FORCE 5'h10
`define ST_ACTIVE 31
`define ST_WAIT_A 30
`define ST_WAIT_D 29
`define ST_QUAL_LO 16
`define ST_SRC_LO 2
`define ST_SW 1
`define ST_POR 0
`define ST_RW1C_MASK 32'h63ff0fff
`define IEN_MASK 32'h63ff0fff
`define CT_INIT 0
`define CT_SW_BRINGUP 1
`define CT_SW_ENTRY 2
`define OP_DIS_ASRT 0
`define OP_DIS_DSRT 1
`define OP_USE_QUAL 2
`define POR_RESET 1'b1
`define CLK_MHZ 40
`define ASRT_STEP_NS 100
`define HOLD_NS 500
`define DSRT_STEP_NS 100
`define ASRT_CYC ((`ASRT_STEP_NS * `CLK_MHZ + 999) / 1000)
`define HOLD_CYC ((`HOLD_NS * `CLK_MHZ + 999) / 1000)
`define DSRT_CYC ((`DSRT_STEP_NS * `CLK_MHZ + 999) / 1000)
`endif

// File: src/rseq_pkg.sv
// Types shared by the reset sequencer modules
package rseq_pkg;
    typedef logic [9:0] line_vec_t;
    typedef logic [9:0] count_t;
    typedef enum logic [5:0] {
        SQ_IDLE = 6'b000001,
        SQ_ASRT = 6'b000010,
        SQ_PAUSE_A = 6'b000100,
        SQ_HOLD = 6'b001000,
        SQ_DSRT = 6'b010000,
        SQ_PAUSE_D = 6'b100000
    } seq_state_t;
endpackage

// File: src/rseq_in_if.sv
// Synchronised input levels and rising-edge pulses
`timescale 1ns/1ps
interface rseq_in_if;
    import rseq_pkg::*;
    line_vec_t src_lvl;
    line_vec_t src_rise;
    line_vec_t qual_lvl;
    line_vec_t qual_rise;
    modport drv (output src_lvl, output src_rise, output qual_lvl, output qual_rise);
    modport use_side (input src_lvl, input src_rise, input qual_lvl, input qual_rise);
endinterface

// File: src/rseq_sync.sv
// Two-stage synchronisers and edge detection for reset and qualifier pins
`timescale 1ns/1ps
module rseq_sync (
    input wire logic clk, // Sequencer clock
    input wire logic nrst, // Async reset, active low
    input wire rseq_pkg::line_vec_t src_raw, // Reset source pins
    input wire rseq_pkg::line_vec_t qual_raw, // Qualifier pins
    rseq_in_if.drv sig // Synchronised outputs
);
    import rseq_pkg::*;
    line_vec_t src_m_q, src_s_q, src_p_q;
    line_vec_t qual_m_q, qual_s_q, qual_p_q;

    // Two flops, then a delay flop for edge detection
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            src_m_q <= 10'h000;
            src_s_q <= 10'h000;
            src_p_q <= 10'h000;
            qual_m_q <= 10'h000;
            qual_s_q <= 10'h000;
            qual_p_q <= 10'h000;
        end else begin
            src_m_q <= src_raw;
            src_s_q <= src_m_q;
            src_p_q <= src_s_q;
            qual_m_q <= qual_raw;
            qual_s_q <= qual_m_q;
            qual_p_q <= qual_s_q;
        end
    end

    // Levels and one-cycle assertion pulses
    assign sig.src_lvl = src_s_q;
    assign sig.src_rise = src_s_q & ~src_p_q;
    assign sig.qual_lvl = qual_s_q;
    assign sig.qual_rise = qual_s_q & ~qual_p_q;
endmodule // rseq_sync

// File: src/rseq_timer.sv
// Saturating step counter with a reached flag
`timescale 1ns/1ps
module rseq_timer (
    input wire logic clk, // Sequencer clock
    input wire logic nrst, // Async reset, active low
    input wire logic clr, // Restart count
    input wire rseq_pkg::count_t limit, // Cycles to wait
    output logic done // Limit reached
);
    import rseq_pkg::*;
    count_t cnt_q;

    // Count up, hold at all ones
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 10'h000;
        end else if (clr) begin
            cnt_q <= 10'h000;
        end else if (cnt_q != 10'h3ff) begin
            cnt_q <= cnt_q + 10'h001;
        end
    end

    // No stale reached flag while a restart is pending, else a phase would step twice
    assign done = !clr && (cnt_q >= limit);
endmodule // rseq_timer

// File: src/rseq_status_top.sv
// Reset sequencer with cause log, control registers and output override
`timescale 1ns/1ps
`include "rseq_consts.svh"
module rseq_status_top (
    input wire logic REF_CLK, // 40 MHz clock
    input wire logic NRST, // Async reset, active low
    input wire rseq_pkg::line_vec_t SOURCE_RESET_LINE, // Reset sources, high
    input wire rseq_pkg::line_vec_t QUAL_LINE, // Qualifiers, high
    input wire logic [4:0] CSR_ADDR, // Byte address
    input wire logic CSR_WR, // Write strobe
    input wire logic CSR_RD, // Read strobe
    input wire logic [31:0] CSR_WDATA, // Write data
    output logic [31:0] CSR_RDATA, // Read data, next cycle
    output rseq_pkg::line_vec_t RESET_OUT, // Sequenced resets, high
    output logic IRQ // Interrupt request, high
);
    import rseq_pkg::*;

    // Width-fitted timing limits
    localparam count_t ASRT_LIM = count_t'(`ASRT_CYC);
    localparam count_t HOLD_LIM = count_t'(`HOLD_CYC);
    localparam count_t DSRT_LIM = count_t'(`DSRT_CYC);

    // Word address match
    function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
        hit = (addr[4:2] == ofs[4:2]);
    endfunction

    rseq_in_if in_sig();

    // Pin synchronisers
    rseq_sync u_sync (
        .clk(REF_CLK),
        .nrst(NRST),
        .src_raw(SOURCE_RESET_LINE),
        .qual_raw(QUAL_LINE),
        .sig(in_sig)
    );

    seq_state_t state_q;
    line_vec_t seq_q;
    logic [3:0] idx_q;
    logic tmr_clr_q;
    logic tmr_done;
    count_t tmr_lim;

    // Step delay counter
    rseq_timer u_timer (
        .clk(REF_CLK),
        .nrst(NRST),
        .clr(tmr_clr_q),
        .limit(tmr_lim),
        .done(tmr_done)
    );

    logic wait_a_q;
    logic wait_d_q;
    line_vec_t qual_log_q;
    line_vec_t src_log_q;
    logic sw_log_q;
    logic por_q;
    logic [31:0] ien_q;
    logic sw_entry_q;
    logic sw_bringup_q;
    logic dis_asrt_q;
    logic dis_dsrt_q;
    logic use_qual_q;
    line_vec_t force_q;
    line_vec_t out_q;
    logic [31:0] rdata_q;
    logic irq_q;

    // Bus decode
    logic wr_status;
    logic wr_ien;
    logic wr_ctrl;
    logic wr_option;
    logic wr_force;
    logic [31:0] w1c;
    assign wr_status = CSR_WR && hit(CSR_ADDR, `OFS_STATUS);
    assign wr_ien = CSR_WR && hit(CSR_ADDR, `OFS_IRQ_EN);
    assign wr_ctrl = CSR_WR && hit(CSR_ADDR, `OFS_CTRL);
    assign wr_option = CSR_WR && hit(CSR_ADDR, `OFS_OPTION);
    assign wr_force = CSR_WR && hit(CSR_ADDR, `OFS_FORCE);
    assign w1c = wr_status ? (CSR_WDATA & `ST_RW1C_MASK) : 32'h0000_0000;

    // Sequence events
    logic active;
    logic sw_start;
    logic hw_start;
    logic start;
    logic set_wait_a;
    logic set_wait_d;
    assign active = (state_q != SQ_IDLE);
    assign sw_start = wr_ctrl && CSR_WDATA[`CT_INIT] && !active;
    assign hw_start = |in_sig.src_rise;
    assign start = !active && (sw_start || hw_start);

    // Step readiness; software stepping ignores timers and qualifiers
    logic asrt_ready;
    logic dsrt_ready;
    logic qual_ok;
    assign qual_ok = in_sig.qual_lvl[idx_q];
    assign asrt_ready = sw_entry_q || tmr_done;
    assign dsrt_ready = sw_bringup_q || (use_qual_q ? qual_ok : tmr_done);
    assign set_wait_a = (state_q == SQ_ASRT) && !dis_asrt_q && asrt_ready && sw_entry_q;
    assign set_wait_d = (state_q == SQ_DSRT) && !dis_dsrt_q && dsrt_ready && sw_bringup_q;

    // Limit used by the current phase
    always_comb begin
        unique case (state_q)
            SQ_HOLD: tmr_lim = HOLD_LIM;
            SQ_DSRT: tmr_lim = DSRT_LIM;
            default: tmr_lim = ASRT_LIM;
        endcase
    end

    // Sequencer state machine
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= SQ_IDLE;
            seq_q <= 10'h000;
            idx_q <= 4'h0;
            tmr_clr_q <= 1'b1;
        end else begin
            tmr_clr_q <= 1'b0;
            unique case (state_q)
                SQ_IDLE: begin
                    if (start) begin
                        state_q <= SQ_ASRT;
                        idx_q <= 4'h0;
                        tmr_clr_q <= 1'b1;
                    end
                end
                SQ_ASRT: begin
                    if (dis_asrt_q) begin
                        seq_q <= 10'h3ff;
                        state_q <= SQ_HOLD;
                        tmr_clr_q <= 1'b1;
                    end else if (asrt_ready) begin
                        seq_q[idx_q] <= 1'b1;
                        idx_q <= (idx_q == 4'h9) ? 4'h0 : idx_q + 4'h1;
                        tmr_clr_q <= 1'b1;
                        if (sw_entry_q) begin
                            state_q <= SQ_PAUSE_A;
                        end else if (idx_q == 4'h9) begin
                            state_q <= SQ_HOLD;
                        end
                    end
                end
                SQ_PAUSE_A: begin
                    if (!wait_a_q) begin
                        state_q <= (&seq_q) ? SQ_HOLD : SQ_ASRT;
                        tmr_clr_q <= 1'b1;
                    end
                end
                SQ_HOLD: begin
                    if (tmr_done && !(|in_sig.src_lvl)) begin
                        state_q <= SQ_DSRT;
                        idx_q <= 4'h0;
                        tmr_clr_q <= 1'b1;
                    end
                end
                SQ_DSRT: begin
                    if (dis_dsrt_q) begin
                        seq_q <= 10'h000;
                        state_q <= SQ_IDLE;
                    end else if (dsrt_ready) begin
                        seq_q[idx_q] <= 1'b0;
                        idx_q <= (idx_q == 4'h9) ? 4'h0 : idx_q + 4'h1;
                        tmr_clr_q <= 1'b1;
                        if (sw_bringup_q) begin
                            state_q <= SQ_PAUSE_D;
                        end else if (idx_q == 4'h9) begin
                            state_q <= SQ_IDLE;
                        end
                    end
                end
                SQ_PAUSE_D: begin
                    if (!wait_d_q) begin
                        state_q <= (|seq_q) ? SQ_DSRT : SQ_IDLE;
                        tmr_clr_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Waiting-for-software flags; a new wait wins over a clear
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            wait_a_q <= 1'b0;
            wait_d_q <= 1'b0;
        end else begin
            wait_a_q <= (wait_a_q & ~w1c[`ST_WAIT_A]) | set_wait_a;
            wait_d_q <= (wait_d_q & ~w1c[`ST_WAIT_D]) | set_wait_d;
        end
    end

    // Cause log; set wins over clear
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            qual_log_q <= 10'h000;
            src_log_q <= 10'h000;
            sw_log_q <= 1'b0;
        end else begin
            qual_log_q <= (qual_log_q & ~w1c[`ST_QUAL_LO +: 10]) | in_sig.qual_rise;
            src_log_q <= (src_log_q & ~w1c[`ST_SRC_LO +: 10]) | in_sig.src_rise;
            sw_log_q <= (sw_log_q & ~w1c[`ST_SW]) | sw_start;
        end
    end

    // Power-on cause: set by own reset, cleared only by software
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            por_q <= `POR_RESET;
        end else if (w1c[`ST_POR]) begin
            por_q <= 1'b0;
        end
    end

    // Control, option and enable registers
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            ien_q <= 32'h0000_0000;
            sw_entry_q <= 1'b0;
            sw_bringup_q <= 1'b0;
            dis_asrt_q <= 1'b0;
            dis_dsrt_q <= 1'b0;
            use_qual_q <= 1'b0;
            force_q <= 10'h000;
        end else begin
            if (wr_ien) begin
                ien_q <= CSR_WDATA & `IEN_MASK;
            end
            if (wr_ctrl) begin
                sw_entry_q <= CSR_WDATA[`CT_SW_ENTRY];
                sw_bringup_q <= CSR_WDATA[`CT_SW_BRINGUP];
            end
            if (wr_option) begin
                dis_asrt_q <= CSR_WDATA[`OP_DIS_ASRT];
                dis_dsrt_q <= CSR_WDATA[`OP_DIS_DSRT];
                use_qual_q <= CSR_WDATA[`OP_USE_QUAL];
            end
            if (wr_force) begin
                force_q <= CSR_WDATA[9:0];
            end
        end
    end

    // Assembled status word, reserved bits zero
    logic [31:0] status;
    always_comb begin
        status = 32'h0000_0000;
        status[`ST_ACTIVE] = active;
        status[`ST_WAIT_A] = wait_a_q;
        status[`ST_WAIT_D] = wait_d_q;
        status[`ST_QUAL_LO +: 10] = qual_log_q;
        status[`ST_SRC_LO +: 10] = src_log_q;
        status[`ST_SW] = sw_log_q;
        status[`ST_POR] = por_q;
    end

    // Read data; unmapped and write-only bits read zero
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_q <= 32'h0000_0000;
        end else if (CSR_RD) begin
            rdata_q <= 32'h0000_0000;
            if (hit(CSR_ADDR, `OFS_STATUS)) begin
                rdata_q <= status;
            end else if (hit(CSR_ADDR, `OFS_IRQ_EN)) begin
                rdata_q <= ien_q;
            end else if (hit(CSR_ADDR, `OFS_CTRL)) begin
                rdata_q <= {29'h0, sw_entry_q, sw_bringup_q, 1'b0};
            end else if (hit(CSR_ADDR, `OFS_OPTION)) begin
                rdata_q <= {29'h0, use_qual_q, dis_dsrt_q, dis_asrt_q};
            end else if (hit(CSR_ADDR, `OFS_FORCE)) begin
                rdata_q <= {22'h0, force_q};
            end
        end
    end

    // Reset outputs: sequencer OR software force
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            out_q <= 10'h000;
        end else begin
            out_q <= seq_q | force_q;
        end
    end

    // Interrupt from enabled status bits
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status & ien_q & `IEN_MASK);
        end
    end

    assign CSR_RDATA = rdata_q;
    assign RESET_OUT = out_q;
    assign IRQ = irq_q;
endmodule // rseq_status_top

// File: test/rseq_status_assertions.sv
// Concurrent checks on the reset sequencer ports
`timescale 1ns/1ps
`include "rseq_consts.svh"
module rseq_status_assertions (
    input wire logic REF_CLK, // Clock
    input wire logic NRST, // Reset, active low
    input wire rseq_pkg::line_vec_t SOURCE_RESET_LINE, // Sources
    input wire rseq_pkg::line_vec_t QUAL_LINE, // Qualifiers
    input wire logic [4:0] CSR_ADDR, // Address
    input wire logic CSR_WR, // Write strobe
    input wire logic CSR_RD, // Read strobe
    input wire logic [31:0] CSR_WDATA, // Write data
    input wire logic [31:0] CSR_RDATA, // Read data
    input wire rseq_pkg::line_vec_t RESET_OUT, // Resets out
    input wire logic IRQ // Interrupt
);
    import rseq_pkg::*;
    // One clock domain, quiet during reset
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);
    // Status word contents
    AST_RSV_ZERO: assert property (
        CSR_RD && CSR_ADDR == `OFS_STATUS |=> (CSR_RDATA & 32'h1c00f000) == 32'h0)
        else $error("reserved status bits nonzero");
    AST_W1C_POR: assert property (
        (CSR_WR && CSR_ADDR == `OFS_STATUS && CSR_WDATA[0] ##2 CSR_RD
        && CSR_ADDR == `OFS_STATUS) |=> !CSR_RDATA[0])
        else $error("power-on bit not cleared by write one");
    AST_KEEP_POR: assert property (
        (CSR_RD && CSR_ADDR == `OFS_STATUS ##2 CSR_WR && CSR_ADDR == `OFS_STATUS
        && !CSR_WDATA[0] && CSR_RDATA[0] ##2 CSR_RD && CSR_ADDR == `OFS_STATUS)
        |=> CSR_RDATA[0]) else $error("power-on bit lost on write zero");
    AST_START: assert property (
        (CSR_WR && CSR_ADDR == `OFS_CTRL && CSR_WDATA[0] ##2 CSR_RD
        && CSR_ADDR == `OFS_STATUS) |=> CSR_RDATA[31])
        else $error("initiate did not start a sequence");
    AST_SRC_LOG: assert property (
        ($rose(SOURCE_RESET_LINE[3]) ##9 CSR_RD && CSR_ADDR == `OFS_STATUS)
        |=> CSR_RDATA[5]) else $error("source line not logged");
    AST_QUAL_LOG: assert property (
        ($rose(QUAL_LINE[0]) ##7 CSR_RD && CSR_ADDR == `OFS_STATUS)
        |=> CSR_RDATA[16]) else $error("qualifier not logged");
    // Outputs driven from registers
    AST_FORCE: assert property (
        CSR_WR && CSR_ADDR == `OFS_FORCE |-> ##2
        (RESET_OUT & $past(CSR_WDATA[9:0], 2)) == $past(CSR_WDATA[9:0], 2))
        else $error("forced output not high");
    AST_IRQ_MASKED: assert property (
        CSR_WR && CSR_ADDR == `OFS_IRQ_EN && CSR_WDATA == 32'h0 |-> ##2 !IRQ)
        else $error("interrupt with all enables off");
endmodule // rseq_status_assertions
bind rseq_status_top rseq_status_assertions i_chk (.REF_CLK(REF_CLK), .NRST(NRST),
    .SOURCE_RESET_LINE(SOURCE_RESET_LINE), .QUAL_LINE(QUAL_LINE), .CSR_ADDR(CSR_ADDR),
    .CSR_WR(CSR_WR), .CSR_RD(CSR_RD), .CSR_WDATA(CSR_WDATA), .CSR_RDATA(CSR_RDATA),
    .RESET_OUT(RESET_OUT), .IRQ(IRQ));

// File: test/csr_host.sv
// Processor model driving the control/status port
`timescale 1ns/1ps
module csr_host (
    input wire logic clk, // Sequencer clock
    output logic [4:0] addr, // Byte address
    output logic wr, // Write strobe
    output logic rd, // Read strobe
    output logic [31:0] wdata, // Write data
    input wire logic [31:0] rdata // Read data
);
    // Idle bus values
    initial begin
        addr = 5'h1f;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 32'h0;
    end
    // One-cycle write; idle lines then carry the inverse, not the old value
    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask
    // One-cycle read; data taken a cycle after the strobe
    task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        addr = ~a;
        d = rdata;
    endtask
endmodule // csr_host

// File: test/tb.sv
// Self-checking bench for the reset sequencer cause log
`timescale 1ns/1ps
`include "rseq_consts.svh"
module tb;
    import rseq_pkg::*;
    logic ref_clk;
    logic nrst;
    line_vec_t src;
    line_vec_t qual;
    logic [4:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
    logic [31:0] rdata;
    line_vec_t rst_out;
    logic irq;
    int error_cnt;
    int samples_checked;
    int cyc;
    logic [31:0] v;
    rseq_status_top i_dut (.REF_CLK(ref_clk), .NRST(nrst), .SOURCE_RESET_LINE(src),
        .QUAL_LINE(qual), .CSR_ADDR(addr), .CSR_WR(wr), .CSR_RD(rd), .CSR_WDATA(wdata),
        .CSR_RDATA(rdata), .RESET_OUT(rst_out), .IRQ(irq));
    csr_host i_host (.clk(ref_clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
        .rdata(rdata));
    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic print_verdict();
        if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Poll status until masked bits match, bounded
    task automatic wait_st(input logic [31:0] m, input logic [31:0] x);
        int n;
        n = 0;
        do begin
            i_host.rd_reg(`OFS_STATUS, v);
            n++;
        end while ((v & m) !== x && n < 400);
    endtask
    // Wait for the outputs to leave a value, bounded
    task automatic wait_out_not(input line_vec_t x);
        for (int n = 0; n < 400 && rst_out === x; n++) @(negedge ref_clk);
    endtask
    task automatic t_regs();
        i_host.rd_reg(`OFS_STATUS, v);
        chk(v, 32'h1);
        i_host.wr_reg(`OFS_STATUS, 32'hfffffffe);
        i_host.rd_reg(`OFS_STATUS, v);
        chk(v, 32'h1);
        i_host.wr_reg(`OFS_IRQ_EN, 32'h1);
        @(negedge ref_clk);
        chk({31'h0, irq}, 32'h1);
        i_host.wr_reg(`OFS_IRQ_EN, 32'h0);
        @(negedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        i_host.wr_reg(`OFS_STATUS, 32'hffffffff);
        i_host.rd_reg(`OFS_STATUS, v);
        chk(v, 32'h0);
        i_host.rd_reg(5'h14, v);
        chk(v, 32'h0);
    endtask
    // Source starts a sequence; a second source while active is only logged
    task automatic t_src();
        @(negedge ref_clk);
        src = 10'h008;
        repeat (8) @(negedge ref_clk);
        i_host.rd_reg(`OFS_STATUS, v);
        chk(v & 32'h80000fff, 32'h80000020);
        src = 10'h208;
        repeat (8) @(negedge ref_clk);
        src = 10'h000;
        wait_st(32'h80000000, 32'h0);
        chk(v & 32'h80000fff, 32'h00000820);
        chk({22'h0, rst_out}, 32'h0);
        i_host.wr_reg(`OFS_STATUS, 32'h820);
        @(negedge ref_clk);
        qual = 10'h3ff;
        repeat (6) @(negedge ref_clk);
        i_host.rd_reg(`OFS_STATUS, v);
        chk(v, 32'h03ff0000);
        qual = 10'h000;
        i_host.wr_reg(`OFS_STATUS, 32'h03ff0000);
        i_host.rd_reg(`OFS_STATUS, v);
        chk(v, 32'h0);
    endtask
    task automatic t_sw();
        i_host.wr_reg(`OFS_CTRL, 32'h1);
        i_host.rd_reg(`OFS_STATUS, v);
        chk(v & 32'h80000002, 32'h80000002);
        wait_st(32'h80000000, 32'h0);
        chk(v & 32'h80000002, 32'h2);
        i_host.wr_reg(`OFS_OPTION, 32'h3);
        i_host.wr_reg(`OFS_CTRL, 32'h1);
        wait_out_not(10'h000);
        chk({22'h0, rst_out}, 32'h3ff);
        wait_out_not(10'h3ff);
        chk({22'h0, rst_out}, 32'h0);
        wait_st(32'h80000000, 32'h0);
        i_host.wr_reg(`OFS_OPTION, 32'h0);
        i_host.wr_reg(`OFS_STATUS, 32'h2);
    endtask
    // Software-stepped entry and bring-up
    task automatic t_step();
        i_host.wr_reg(`OFS_CTRL, 32'h7);
        for (int i = 0; i < 10; i++) begin
            wait_st(32'h40000000, 32'h40000000);
            chk({22'h0, rst_out}, (32'h1 << (i + 1)) - 1);
            i_host.wr_reg(`OFS_STATUS, 32'h40000000);
        end
        for (int i = 0; i < 10; i++) begin
            wait_st(32'h20000000, 32'h20000000);
            chk({22'h0, rst_out}, (32'h3ff << (i + 1)) & 32'h3ff);
            i_host.wr_reg(`OFS_STATUS, 32'h20000000);
        end
        i_host.wr_reg(`OFS_CTRL, 32'h0);
        wait_st(32'h80000000, 32'h0);
        chk({22'h0, rst_out}, 32'h0);
    endtask
    // Qualified bring-up holds until the qualifiers rise; force and own reset
    task automatic t_misc();
        i_host.wr_reg(`OFS_OPTION, 32'h4);
        i_host.wr_reg(`OFS_CTRL, 32'h1);
        repeat (300) @(negedge ref_clk);
        chk({22'h0, rst_out}, 32'h3ff);
        qual = 10'h3ff;
        wait_st(32'h80000000, 32'h0);
        chk({22'h0, rst_out}, 32'h0);
        qual = 10'h000;
        i_host.wr_reg(`OFS_OPTION, 32'h0);
        i_host.wr_reg(`OFS_FORCE, 32'h155);
        @(negedge ref_clk);
        chk({22'h0, rst_out}, 32'h155);
        i_host.wr_reg(`OFS_FORCE, 32'h0);
        src = 10'h001;
        repeat (8) @(negedge ref_clk);
        nrst = 1'b0;
        src = 10'h000;
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        i_host.rd_reg(`OFS_STATUS, v);
        chk(v, 32'h1);
    endtask
    // Hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        nrst = 1'b0;
        src = 10'h000;
        qual = 10'h000;
        error_cnt = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        t_regs();
        t_src();
        t_sw();
        t_step();
        t_misc();
        print_verdict();
    end
endmodule // tb
